//--- fcs_sync.sv
/*
  Shared constants for the flash command sequencer host, plus a
  parameterised two-stage synchroniser for the flash pins it reads.
  Assumes one clock, i_clk at 40 MHz, and an active-low async reset.
*/

// ****************************************************************
// constants shared by the host controller
// ****************************************************************
package fcs_pkg;
  // command bytes written to the flash
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;

  // status byte field positions
  localparam int SR_READY      = 7;
  localparam int SR_PAUSED     = 6;
  localparam int SR_ERASE_ERR  = 5;
  localparam int SR_PROG_ERR   = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam logic [7:0] SR_RSVD_MASK = 8'h07;

  // array geometry: sixteen blocks of 64 Kbyte
  localparam int ADDR_W    = 20;
  localparam int BLOCK_LSB = 16;
  localparam int BLOCK_W   = 4;

  // user operations
  typedef enum logic [3:0] {
    OP_READ_ARRAY  = 4'h0,
    OP_READ_STATUS = 4'h1,
    OP_CLEAR       = 4'h2,
    OP_ERASE       = 4'h3,
    OP_WRITE       = 4'h4,
    OP_SUSPEND     = 4'h5,
    OP_RESUME      = 4'h6,
    OP_POLL        = 4'h7,
    OP_READ_BYTE   = 4'h8
  } fcs_op_t;
  localparam logic [3:0] OP_LAST = 4'h8;

  // timing, in ns, and derived cycle counts (least times round up)
  localparam int CLK_NS    = 25;
  localparam int CLK_KHZ   = 40000;
  localparam int T_WP_NS   = 50;
  localparam int T_WH_NS   = 25;
  localparam int T_ACC_NS  = 85;
  localparam int T_RB_NS   = 100;
  localparam int T_VPP_NS  = 1000;
  localparam int SYNC_N    = 2;
  localparam int CNT_W     = 8;
  localparam logic [CNT_W-1:0] WP_CYC =
    CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WH_CYC =
    CNT_W'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ACC_CYC =
    CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_N);
  localparam logic [CNT_W-1:0] RB_CYC =
    CNT_W'((T_RB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] VPP_CYC =
    CNT_W'((T_VPP_NS + CLK_NS - 1) / CLK_NS);

  // typical erase of 1.6 s; timeout allows four times that
  localparam int ERASE_TYP_MS = 1600;
  localparam int TMO_FACTOR   = 4;
  localparam int unsigned TMO_CYC_DEFAULT =
    ERASE_TYP_MS * CLK_KHZ * TMO_FACTOR;
endpackage

// ****************************************************************
// two flip-flop synchroniser
// ****************************************************************
module fcs_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = i_d;
    q_next    = meta_reg;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign o_q = q_reg;
endmodule // fcs_sync

//--- fcs_host.sv
/*
  Host-side controller for a byte-wide flash with an embedded
  sequencer: turns user operations into write and read bus cycles on
  the flash pins, polls status and tracks erase and suspend state.
  Assumes the flash pins are asynchronous to i_clk, that the user
  port is on i_clk, and that the board turns dq with dq_oe.
*/
// How it works
// - strobes released high between status reads
// - host refuses erase or write while supply-low is flagged
// - erase is 20H then D0H in block
// - suspended: only array, status, resume and byte reads outside the erase block accepted
// - write is 40H then address and data

module fcs_host #(
  parameter int unsigned TMO_CYCLES = fcs_pkg::TMO_CYC_DEFAULT
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  // user side
  input  wire logic                      i_cmd_valid,
  input  wire logic [3:0]                i_cmd_op,
  input  wire logic [fcs_pkg::ADDR_W-1:0] i_cmd_addr,
  input  wire logic [7:0]                i_cmd_data,
  input  wire logic                      i_powerdown,
  output logic                           o_cmd_ready,
  output logic                           o_done,
  output logic                           o_refused,
  output logic                           o_timeout,
  output logic [7:0]                     o_rdata,
  output logic [7:0]                     o_status,
  output logic                           o_supply_low,
  output logic                           o_erase_active,
  output logic                           o_suspended,
  // flash pins
  output logic [fcs_pkg::ADDR_W-1:0]     o_flash_addr,
  output logic [7:0]                     o_flash_dq_out,
  output logic                           o_flash_dq_oe,
  input  wire logic [7:0]                i_flash_dq_in,
  output logic                           o_flash_ce_n,
  output logic                           o_flash_oe_n,
  output logic                           o_flash_we_n,
  output logic                           o_reset_powerdown_n,
  output logic                           o_vpp_enable,
  input  wire logic                      i_ready_busy_out
);
  localparam int CW = fcs_pkg::CNT_W;
  localparam int AW = fcs_pkg::ADDR_W;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_VPP    = 7'h02,
    ST_WLOW   = 7'h04,
    ST_WHIGH  = 7'h08,
    ST_RBWAIT = 7'h10,
    ST_RLOW   = 7'h20,
    ST_RHIGH  = 7'h40
  } fcs_state_t;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [8:0] pin_q;

  fcs_sync #(.W(9)) u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       ({i_ready_busy_out, i_flash_dq_in}),
    .o_q       (pin_q)
  );

  // ****************************************************************
  // state and next values
  // ****************************************************************
  fcs_state_t        state_reg, state_next;
  fcs_pkg::fcs_op_t  op_reg, op_next;
  logic              step_reg, step_next;
  logic [CW-1:0]     cnt_reg, cnt_next;
  logic [31:0]       tmo_reg, tmo_next;
  logic [AW-1:0]     addr_reg, addr_next;
  logic [7:0]        data_reg, data_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic [7:0]        status_reg, status_next;
  logic [fcs_pkg::BLOCK_W-1:0] blk_reg, blk_next;
  logic              slow_reg, slow_next;
  logic              erase_reg, erase_next;
  logic              susp_reg, susp_next;
  logic              ready_reg, ready_next;
  logic              done_reg, done_next;
  logic              refused_reg, refused_next;
  logic              tmo_hit_reg, tmo_hit_next;
  logic [7:0]        dq_out_reg, dq_out_next;
  logic              dq_oe_reg, dq_oe_next;
  logic              ce_n_reg, ce_n_next;
  logic              oe_n_reg, oe_n_next;
  logic              we_n_reg, we_n_next;
  logic              rp_n_reg, rp_n_next;
  logic              vpp_reg, vpp_next;
  logic              refuse;
  logic              finish;
  fcs_pkg::fcs_op_t  in_op;

  // byte placed on dq for a given operation and write step
  function automatic logic [7:0] cmd_byte(input fcs_pkg::fcs_op_t op,
                                          input logic step,
                                          input logic [7:0] data);
    logic [7:0] b;
    b = fcs_pkg::CMD_READ_ARRAY;
    unique case (op)
      fcs_pkg::OP_READ_STATUS: b = fcs_pkg::CMD_READ_STATUS;
      fcs_pkg::OP_CLEAR:       b = fcs_pkg::CMD_CLEAR_STATUS;
      fcs_pkg::OP_ERASE:       b = step ? fcs_pkg::CMD_CONFIRM
                                        : fcs_pkg::CMD_ERASE_SETUP;
      fcs_pkg::OP_WRITE:       b = step ? data
                                        : fcs_pkg::CMD_WRITE_SETUP;
      fcs_pkg::OP_SUSPEND:     b = fcs_pkg::CMD_SUSPEND;
      fcs_pkg::OP_RESUME:      b = fcs_pkg::CMD_CONFIRM;
      default:                 b = fcs_pkg::CMD_READ_ARRAY;
    endcase
    return b;
  endfunction

  // acceptance check; the flash would refuse these anyway, so the
  // host keeps them off the bus rather than cause sequence errors
  always_comb begin
    in_op  = fcs_pkg::fcs_op_t'(i_cmd_op);
    refuse = 1'b0;
    if (i_cmd_op > fcs_pkg::OP_LAST) begin
      refuse = 1'b1;
    end else if (susp_reg) begin
      refuse = !(in_op inside {fcs_pkg::OP_READ_ARRAY,
                 fcs_pkg::OP_READ_STATUS, fcs_pkg::OP_RESUME,
                 fcs_pkg::OP_READ_BYTE});
      if (in_op == fcs_pkg::OP_READ_BYTE &&
          i_cmd_addr[AW-1:fcs_pkg::BLOCK_LSB] == blk_reg) begin
        refuse = 1'b1;
      end
    end else if (erase_reg) begin
      refuse = !(in_op inside {fcs_pkg::OP_SUSPEND,
                 fcs_pkg::OP_POLL, fcs_pkg::OP_READ_STATUS});
    end else begin
      refuse = in_op inside {fcs_pkg::OP_SUSPEND,
               fcs_pkg::OP_RESUME, fcs_pkg::OP_POLL};
      if (slow_reg && in_op inside {fcs_pkg::OP_ERASE,
                                    fcs_pkg::OP_WRITE}) begin
        refuse = 1'b1;
      end
    end
  end

  // ****************************************************************
  // sequencer next-state logic
  // ****************************************************************
  always_comb begin
    state_next   = state_reg;
    op_next      = op_reg;
    step_next    = step_reg;
    cnt_next     = cnt_reg + 1'b1;
    tmo_next     = tmo_reg;
    addr_next    = addr_reg;
    data_next    = data_reg;
    rdata_next   = rdata_reg;
    status_next  = status_reg;
    blk_next     = blk_reg;
    slow_next    = slow_reg;
    erase_next   = erase_reg;
    susp_next    = susp_reg;
    done_next    = 1'b0;
    refused_next = 1'b0;
    tmo_hit_next = 1'b0;
    finish       = 1'b0;
    if (i_powerdown) begin
      // abort: the flash halts and leaves its target half done
      state_next = ST_IDLE;
      erase_next = 1'b0;
      susp_next  = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cnt_next = '0;
          tmo_next = '0;
          if (i_cmd_valid && ready_reg) begin
            if (refuse) begin
              refused_next = 1'b1;
            end else begin
              op_next   = in_op;
              step_next = 1'b0;
              addr_next = i_cmd_addr;
              data_next = i_cmd_data;
              if (in_op == fcs_pkg::OP_ERASE) begin
                blk_next = i_cmd_addr[AW-1:fcs_pkg::BLOCK_LSB];
              end
              // status and clear go out with the supply low
              unique case (in_op)
                fcs_pkg::OP_ERASE, fcs_pkg::OP_WRITE:
                  state_next = ST_VPP;
                fcs_pkg::OP_POLL:      state_next = ST_RBWAIT;
                fcs_pkg::OP_READ_BYTE: state_next = ST_RLOW;
                default:               state_next = ST_WLOW;
              endcase
            end
          end
        end
        ST_VPP: begin
          if (cnt_reg == fcs_pkg::VPP_CYC - 1'b1) begin
            state_next = ST_WLOW;
            cnt_next   = '0;
          end
        end
        ST_WLOW: begin
          if (cnt_reg == fcs_pkg::WP_CYC - 1'b1) begin
            state_next = ST_WHIGH;
            cnt_next   = '0;
          end
        end
        ST_WHIGH: begin
          if (cnt_reg == fcs_pkg::WH_CYC - 1'b1) begin
            cnt_next = '0;
            if (!step_reg && op_reg inside {fcs_pkg::OP_ERASE,
                                            fcs_pkg::OP_WRITE}) begin
              // confirm follows setup directly, never another byte
              step_next  = 1'b1;
              state_next = ST_WLOW;
            end else if (op_reg == fcs_pkg::OP_READ_STATUS) begin
              state_next = ST_RLOW;
            end else if (op_reg inside {fcs_pkg::OP_WRITE,
                                        fcs_pkg::OP_SUSPEND}) begin
              // nothing but status may reach a busy write
              state_next = ST_RBWAIT;
            end else begin
              finish = 1'b1;
            end
          end
        end
        ST_RBWAIT: begin
          tmo_next = tmo_reg + 1'b1;
          if (cnt_reg >= fcs_pkg::RB_CYC - 1'b1) begin
            cnt_next = cnt_reg;
          end
          if (tmo_reg >= TMO_CYCLES) begin
            state_next   = ST_IDLE;
            tmo_hit_next = 1'b1;
          end else if (cnt_reg >= fcs_pkg::RB_CYC - 1'b1 &&
                       pin_q[8]) begin
            state_next = ST_RLOW;
            cnt_next   = '0;
          end
        end
        ST_RLOW: begin
          if (cnt_reg == fcs_pkg::ACC_CYC - 1'b1) begin
            rdata_next = pin_q[7:0];
            if (op_reg != fcs_pkg::OP_READ_BYTE) begin
              status_next = pin_q[7:0] & ~fcs_pkg::SR_RSVD_MASK;
              slow_next = slow_reg | pin_q[fcs_pkg::SR_SUPPLY_LOW];
            end
            state_next = ST_RHIGH;
            cnt_next   = '0;
          end
        end
        ST_RHIGH: begin
          // strobes high here so the next read latches fresh status
          if (cnt_reg == fcs_pkg::WH_CYC - 1'b1) begin
            cnt_next = '0;
            if (op_reg inside {fcs_pkg::OP_WRITE, fcs_pkg::OP_SUSPEND,
                               fcs_pkg::OP_POLL} &&
                !status_reg[fcs_pkg::SR_READY]) begin
              state_next = ST_RBWAIT;
            end else begin
              finish = 1'b1;
            end
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end

    // completion effects on tracked flash state
    if (finish) begin
      state_next = ST_IDLE;
      done_next  = 1'b1;
      unique case (op_reg)
        fcs_pkg::OP_CLEAR:  slow_next  = 1'b0;
        fcs_pkg::OP_ERASE:  erase_next = 1'b1;
        fcs_pkg::OP_RESUME: begin
          susp_next  = 1'b0;
          erase_next = 1'b1;
        end
        fcs_pkg::OP_SUSPEND: begin
          erase_next = 1'b0;
          susp_next  = status_reg[fcs_pkg::SR_PAUSED];
        end
        fcs_pkg::OP_POLL: erase_next = 1'b0;
        default: ;
      endcase
    end
  end

  // pin values follow the next state so every pin is a flop
  always_comb begin
    ready_next  = (state_next == ST_IDLE) && !i_powerdown;
    ce_n_next   = !(state_next inside {ST_WLOW, ST_WHIGH, ST_RLOW});
    we_n_next   = !(state_next == ST_WLOW);
    oe_n_next   = !(state_next == ST_RLOW);
    dq_oe_next  = state_next inside {ST_WLOW, ST_WHIGH};
    dq_out_next = cmd_byte(op_next, step_next, data_next);
    rp_n_next   = !i_powerdown;
    vpp_next    = ((state_next != ST_IDLE) &&
                   op_next inside {fcs_pkg::OP_ERASE, fcs_pkg::OP_WRITE})
                  || erase_next || susp_next;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg   <= ST_IDLE;
      op_reg      <= fcs_pkg::OP_READ_ARRAY;
      step_reg    <= 1'b0;
      cnt_reg     <= '0;
      tmo_reg     <= '0;
      addr_reg    <= '0;
      data_reg    <= '0;
      rdata_reg   <= '0;
      status_reg  <= '0;
      blk_reg     <= '0;
      slow_reg    <= 1'b0;
      erase_reg   <= 1'b0;
      susp_reg    <= 1'b0;
      ready_reg   <= 1'b0;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      tmo_hit_reg <= 1'b0;
      dq_out_reg  <= '0;
      dq_oe_reg   <= 1'b0;
      ce_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      rp_n_reg    <= 1'b0;
      vpp_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      step_reg    <= step_next;
      cnt_reg     <= cnt_next;
      tmo_reg     <= tmo_next;
      addr_reg    <= addr_next;
      data_reg    <= data_next;
      rdata_reg   <= rdata_next;
      status_reg  <= status_next;
      blk_reg     <= blk_next;
      slow_reg    <= slow_next;
      erase_reg   <= erase_next;
      susp_reg    <= susp_next;
      ready_reg   <= ready_next;
      done_reg    <= done_next;
      refused_reg <= refused_next;
      tmo_hit_reg <= tmo_hit_next;
      dq_out_reg  <= dq_out_next;
      dq_oe_reg   <= dq_oe_next;
      ce_n_reg    <= ce_n_next;
      oe_n_reg    <= oe_n_next;
      we_n_reg    <= we_n_next;
      rp_n_reg    <= rp_n_next;
      vpp_reg     <= vpp_next;
    end
  end

  // outputs straight from flops
  assign o_cmd_ready         = ready_reg;
  assign o_done              = done_reg;
  assign o_refused           = refused_reg;
  assign o_timeout           = tmo_hit_reg;
  assign o_rdata             = rdata_reg;
  assign o_status            = status_reg;
  assign o_supply_low        = slow_reg;
  assign o_erase_active      = erase_reg;
  assign o_suspended         = susp_reg;
  assign o_flash_addr        = addr_reg;
  assign o_flash_dq_out      = dq_out_reg;
  assign o_flash_dq_oe       = dq_oe_reg;
  assign o_flash_ce_n        = ce_n_reg;
  assign o_flash_oe_n        = oe_n_reg;
  assign o_flash_we_n        = we_n_reg;
  assign o_reset_powerdown_n = rp_n_reg;
  assign o_vpp_enable        = vpp_reg;
endmodule // fcs_host

//--- fcs_host_checker.sv
/*
  Assertions on the pins and user port of the flash host.
  Assumes one clock domain and a bind onto every fcs_host.
*/
module fcs_host_checker (
  input wire logic                       i_clk,
  input wire logic                       i_reset_n,
  input wire logic                       i_cmd_valid,
  input wire logic [3:0]                 i_cmd_op,
  input wire logic                       i_powerdown,
  input wire logic                       o_cmd_ready,
  input wire logic                       o_refused,
  input wire logic [7:0]                 o_status,
  input wire logic                       o_supply_low,
  input wire logic                       o_erase_active,
  input wire logic                       o_suspended,
  input wire logic [fcs_pkg::ADDR_W-1:0] o_flash_addr,
  input wire logic [7:0]                 o_flash_dq_out,
  input wire logic                       o_flash_dq_oe,
  input wire logic                       o_flash_ce_n,
  input wire logic                       o_flash_oe_n,
  input wire logic                       o_flash_we_n,
  input wire logic                       o_reset_powerdown_n
);
  // ********
  // bus cycle shapes and refusals
  // ********
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  wire take = i_cmd_valid && o_cmd_ready;
  // write strobe two cycles with data driven, then released
  sequence s_wlow;
    (!o_flash_we_n && o_flash_dq_oe && !o_flash_ce_n) [*2] ##1 o_flash_we_n;
  endsequence
  // read strobes six cycles, bus turned, then a gap
  sequence s_rlow;
    (!o_flash_oe_n && !o_flash_ce_n && !o_flash_dq_oe) [*6] ##1 o_flash_oe_n;
  endsequence
  AST_WR_PULSE: assert property ($fell(o_flash_we_n) |-> s_wlow)
    else $error("write strobe shape wrong");
  AST_RD_GAP: assert property ($fell(o_flash_oe_n) |-> s_rlow)
    else $error("read strobe shape wrong");
  AST_WR_HOLD: assert property (!o_flash_we_n
    && !$past(o_flash_we_n)
    |-> $stable(o_flash_dq_out) && $stable(o_flash_addr))
    else $error("address or data moved under write strobe");
  AST_PD: assert property (i_powerdown |=> !o_reset_powerdown_n)
    else $error("powerdown not passed to flash");
  AST_RSVD: assert property ($changed(o_status)
    |-> o_status[2:0] == 3'h0)
    else $error("reserved status bits set");
  AST_SUPPLY: assert property (take && o_supply_low
    && (i_cmd_op == 4'h3 || i_cmd_op == 4'h4) |=> o_refused)
    else $error("operation taken with supply low flagged");
  AST_SUSP: assert property (take && o_suspended
    && !(i_cmd_op inside {4'h0, 4'h1, 4'h6, 4'h8}) |=> o_refused)
    else $error("illegal command taken while suspended");
  AST_BUSY: assert property (take && o_erase_active
    && !(i_cmd_op inside {4'h1, 4'h5, 4'h7}) |=> o_refused)
    else $error("illegal command taken during erase");
endmodule // fcs_host_checker

bind fcs_host fcs_host_checker u_fcs_host_checker (.i_clk, .i_reset_n,
  .i_cmd_valid, .i_cmd_op, .i_powerdown, .o_cmd_ready, .o_refused,
  .o_status, .o_supply_low, .o_erase_active, .o_suspended, .o_flash_addr,
  .o_flash_dq_out, .o_flash_dq_oe, .o_flash_ce_n, .o_flash_oe_n,
  .o_flash_we_n, .o_reset_powerdown_n);

//--- fcs_flash_model.sv
/*
  Behavioural byte-wide flash with an embedded sequencer.
  Assumes a host that drives dq only on writes; no clock of its own.
*/
module fcs_flash_model #(
  parameter int ERASE_TICKS = 20,
  parameter int PROG_TICKS  = 3
) (
  input  wire logic [19:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_rp_n,
  input  wire logic        i_vpp_on,
  output logic [7:0]       o_dq,
  output logic             o_ready_busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // command decode and sequencer
  // ********
  logic [7:0] mem [int];
  logic [7:0] sr   = 8'h80;
  logic [7:0] lat  = 8'h00;
  logic [1:0] pend = 2'h0;  // 1 erase setup, 2 write setup
  logic       stat = 1'b0;
  logic       ers  = 1'b0;
  logic       susp = 1'b0;
  logic       hold = 1'b0;
  logic [3:0] blk  = 4'h0;
  int         left = 0;
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  task automatic go(input logic e, input int n);
    ers = e;
    left = n;
    sr[7] = 1'b0;
    blk = i_addr[19:16];
  endtask
  // commands land on the rising write strobe
  always @(posedge i_we_n) if (!i_ce_n && i_rp_n) begin
    if (pend != 2'h0) begin
      if (pend == 2'h1 && i_dq != 8'hD0) sr[5:4] = 2'b11;
      else if (!i_vpp_on || sr[3]) sr[3] = 1'b1;
      else if (pend == 2'h1) go(1'b1, ERASE_TICKS);
      else begin
        mem[i_addr] = rd(i_addr) & i_dq;
        go(1'b0, PROG_TICKS);
      end
      pend = 2'h0;
      stat = 1'b1;
    end else if (left > 0 && !susp) begin
      if (ers && i_dq == 8'hB0) hold = 1'b1;
    end else if (susp) begin
      if (i_dq == 8'hFF) stat = 1'b0;
      if (i_dq == 8'h70) stat = 1'b1;
      if (i_dq == 8'hD0) begin
        susp = 1'b0;
        sr[7:6] = 2'b00;
        stat = 1'b1;
      end
    end else begin
      case (i_dq)
        8'hFF: stat = 1'b0;
        8'h70: stat = 1'b1;
        8'h50: sr[5:3] = 3'b000;
        8'h20: pend = 2'h1;
        8'h40, 8'h10: pend = 2'h2;
        default: ;
      endcase
    end
  end
  // sequencer steps every 100 ns; a supply drop aborts it
  always #100 if (left > 0 && !susp) begin
    if (hold) begin
      susp = 1'b1;
      hold = 1'b0;
      sr[7:6] = 2'b11;
    end else if (!i_vpp_on) begin
      left = 0;
      sr[3] = 1'b1;
      sr[7] = 1'b1;
    end else begin
      left = left - 1;
      if (left == 0 && ers) begin
        foreach (mem[k]) if (k[19:16] == blk) mem[k] = 8'hFF;
      end
      sr[7] = (left == 0);
    end
  end
  // powerdown halts everything and returns to array reads
  always @(negedge i_rp_n) begin
    left = 0;
    susp = 1'b0;
    hold = 1'b0;
    pend = 2'h0;
    stat = 1'b0;
    sr = 8'h80;
  end
  // status latched at the later falling strobe; idle bus shows garbage
  always @(negedge i_oe_n or negedge i_ce_n)
    if (!i_oe_n && !i_ce_n) lat = stat ? sr : rd(i_addr);
  assign o_dq = (!i_oe_n && !i_ce_n) ? lat : ~lat;
  assign o_ready_busy_out = left == 0 || susp || !i_rp_n;
endmodule // fcs_flash_model

//--- fcs_host_tb.sv
/*
  Self-checking bench: fcs_host driving the behavioural flash.
  Assumes the checker binds itself onto fcs_host.
*/
module fcs_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_cmd_valid = 1'b0;
  logic [3:0]  i_cmd_op = 4'h0;
  logic [19:0] i_cmd_addr = 20'h00000;
  logic [7:0]  i_cmd_data = 8'h00, wd, i_flash_dq_in, o_rdata, o_status;
  logic        i_powerdown = 1'b0, vpp_ok = 1'b1, i_ready_busy_out;
  logic        o_cmd_ready, o_done, o_refused, o_timeout, o_supply_low;
  logic        o_erase_active, o_suspended, o_flash_dq_oe, o_vpp_enable;
  logic        o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_reset_powerdown_n;
  logic [19:0] o_flash_addr;
  logic [7:0]  o_flash_dq_out;
  logic [10:0] exp_q [$]; // care, refused, rdata select, value
  int          err_total = 0, n_checks = 0, seed = 32'h0de0;
  fcs_host #(.TMO_CYCLES(2000)) u_fcs_host (.i_clk, .i_reset_n, .i_cmd_valid,
    .i_cmd_op, .i_cmd_addr, .i_cmd_data, .i_powerdown, .o_cmd_ready, .o_done,
    .o_refused, .o_timeout, .o_rdata, .o_status, .o_supply_low,
    .o_erase_active, .o_suspended, .o_flash_addr, .o_flash_dq_out,
    .o_flash_dq_oe, .i_flash_dq_in, .o_flash_ce_n, .o_flash_oe_n,
    .o_flash_we_n, .o_reset_powerdown_n, .o_vpp_enable, .i_ready_busy_out);
  fcs_flash_model u_fcs_flash_model (.i_addr(o_flash_addr),
    .i_dq(o_flash_dq_out), .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
    .i_we_n(o_flash_we_n), .i_rp_n(o_reset_powerdown_n),
    .i_vpp_on(o_vpp_enable && vpp_ok), .o_dq(i_flash_dq_in),
    .o_ready_busy_out(i_ready_busy_out));
  // ********
  // clock, result monitor, driver
  // ********
  always #12.5 i_clk = ~i_clk;
  // pulses judged mid-cycle, clear of the launching edge
  always @(negedge i_clk) if (o_done || o_refused || o_timeout) begin
    logic [10:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 11'h7FF;
    n_checks++;
    if (o_timeout || o_refused !== e[9] ||
        e[10] && (e[8] ? o_rdata : o_status) !== e[7:0]) begin
      err_total++;
      $display("MISMATCH %0t: %h %h want %h", $time, o_status, o_rdata, e);
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one user operation; bounded waits for take, result and ready
  task automatic op(input logic [3:0] c, input logic [19:0] a,
                    input logic [7:0] d, input logic [10:0] e);
    int n = 0;
    exp_q.push_back(e);
    {i_cmd_op, i_cmd_addr, i_cmd_data, i_cmd_valid} = {c, a, d, 1'b1};
    do @(posedge i_clk); while (!o_cmd_ready && ++n < 3000);
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    while ((exp_q.size() > 0 || !o_cmd_ready) && ++n < 3000) @(negedge i_clk);
    if (n >= 3000) begin
      err_total++;
      $display("MISMATCH %0t: operation hung", $time);
      complete_run();
    end
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_reset_n = 1'b1;
    wd = 8'($random(seed));
    op(4'h1, 20'h0, 8'h0, 11'h480);
    op(4'hF, 20'h0, 8'h0, 11'h200);
    $display("test 1 done");
    op(4'h4, 20'h30010, wd, 11'h480);
    op(4'h0, 20'h0, 8'h0, 11'h000);
    op(4'h8, 20'h30010, 8'h0, {3'h5, wd});
    $display("test 2 done");
    op(4'h3, 20'h3FFFF, 8'h0, 11'h000);
    op(4'h0, 20'h0, 8'h0, 11'h200);
    op(4'h7, 20'h0, 8'h0, 11'h480);
    op(4'h0, 20'h0, 8'h0, 11'h000);
    op(4'h8, 20'h30010, 8'h0, 11'h5FF);
    $display("test 3 done");
    op(4'h3, 20'h50000, 8'h0, 11'h000);
    op(4'h5, 20'h0, 8'h0, 11'h4C0);
    op(4'h8, 20'h5ABCD, 8'h0, 11'h200);
    op(4'h4, 20'h12345, wd, 11'h200);
    op(4'h0, 20'h0, 8'h0, 11'h000);
    op(4'h8, 20'h30010, 8'h0, 11'h5FF);
    op(4'h6, 20'h0, 8'h0, 11'h000);
    op(4'h7, 20'h0, 8'h0, 11'h480);
    $display("test 4 done");
    vpp_ok = 1'b0;
    op(4'h4, 20'h20000, wd, 11'h488);
    op(4'h3, 20'h20000, 8'h0, 11'h200);
    op(4'h2, 20'h0, 8'h0, 11'h000);
    op(4'h1, 20'h0, 8'h0, 11'h480);
    vpp_ok = 1'b1;
    $display("test 5 done");
    op(4'h3, 20'h70000, 8'h0, 11'h000);
    i_powerdown = 1'b1;
    repeat (4) @(negedge i_clk);
    i_powerdown = 1'b0;
    op(4'h1, 20'h0, 8'h0, 11'h480);
    $display("test 6 done");
    complete_run();
  end
endmodule // fcs_host_tb
